// [rtl/tpt_pkg.sv]
// tpt_pkg: register map, field positions, modes and counter constants of the pulse timer
package tpt_pkg;
    // ************************************************************
    // register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [3:0] TPT_IDX_CTL0  = 4'h0;   // 0x00 control zero
    localparam logic [3:0] TPT_IDX_CTL1  = 4'h1;   // 0x04 control one
    localparam logic [3:0] TPT_IDX_IOC2  = 4'h2;   // 0x08 trigger/event edge select
    localparam logic [3:0] TPT_IDX_CCR0  = 4'h3;   // 0x0C cycle compare
    localparam logic [3:0] TPT_IDX_CCR1  = 4'h4;   // 0x10 width compare
    localparam logic [3:0] TPT_IDX_CNT   = 4'h5;   // 0x14 counter read buffer
    localparam logic [3:0] TPT_IDX_IOC1  = 4'h6;   // 0x18 capture input control
    localparam logic [3:0] TPT_IDX_OPT0  = 4'h7;   // 0x1C option zero
    localparam logic [3:0] TPT_IDX_STAT  = 4'h8;   // 0x20 run status
    localparam logic [3:0] TPT_IDX_LAST  = 4'h8;
    localparam int         TPT_IDX_LSB   = 2;
    localparam int         TPT_IDX_MSB   = 5;
    localparam int         TPT_DEC_MSB   = 31;     // bits above the index must be zero
    // ************************************************************
    // field positions and masks
    // ************************************************************
    localparam int         TPT_CE_BIT    = 7;      // count enable in control zero
    localparam int         TPT_EST_BIT   = 6;      // software trigger in control one
    localparam int         TPT_MODE_MSB  = 2;
    localparam logic [7:0] TPT_IOC2_MASK = 8'h0F;  // edge selects, upper bits read zero
    localparam int         TPT_ST_RUN    = 0;
    localparam int         TPT_ST_PEND   = 1;
    // ************************************************************
    // modes, edge codes, counter values
    // ************************************************************
    localparam logic [2:0]  TPT_MODE_RETRIG  = 3'h2;
    localparam logic [2:0]  TPT_MODE_ONESHOT = 3'h3;
    localparam logic [1:0]  TPT_EDGE_NONE    = 2'h0;
    localparam logic [1:0]  TPT_EDGE_RISE    = 2'h1;
    localparam logic [1:0]  TPT_EDGE_FALL    = 2'h2;
    localparam logic [15:0] TPT_CNT_IDLE     = 16'hFFFF;
    localparam logic [15:0] TPT_CNT_ZERO     = 16'h0000;
    localparam logic [15:0] TPT_CNT_ONE      = 16'h0001;
    localparam logic [2:0]  TPT_HSIZE_WORD   = 3'h2;
    localparam logic [1:0]  TPT_HTRANS_NSEQ  = 2'h2;
    typedef enum logic {TPT_BUS_IDLE, TPT_BUS_DATA} tpt_bus_e;
endpackage

// [rtl/tpt_reg_if.sv]
// tpt_reg_if: register access strobes between the bus slave and the timer core
`timescale 1ns/1ps
interface tpt_reg_if;
    logic        wr_stb;   // one-cycle write strobe
    logic        hit;      // index maps to a register
    logic [3:0]  idx;      // word index
    logic [31:0] wdata;
    logic [31:0] rdata;    // combinational read value of idx
    modport slave (output wr_stb, output idx, output wdata, input rdata, input hit);
    modport core  (input wr_stb, input idx, input wdata, output rdata, output hit);
endinterface

// [rtl/tpt_edge_det.sv]
// tpt_edge_det: selectable valid-edge detector for the external trigger input
`timescale 1ns/1ps
module tpt_edge_det
    import tpt_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // pin and selection
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    // detected edge
    output logic            edge_pulse
);
    logic pin_d_reg;
    logic pin_d_next;
    logic rise;
    logic fall;

    // previous pin level, pin is already synchronous
    always_comb begin
        pin_d_next = pin_in;
        rise       = pin_in & ~pin_d_reg;
        fall       = ~pin_in & pin_d_reg;
        case (edge_sel)
            TPT_EDGE_NONE: edge_pulse = 1'b0;
            TPT_EDGE_RISE: edge_pulse = rise;
            TPT_EDGE_FALL: edge_pulse = fall;
            default:       edge_pulse = rise | fall;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= pin_d_next;
        end
    end
endmodule

// [rtl/tpt_ahb_slave.sv]
// tpt_ahb_slave: AHB-Lite slave with one wait state per transfer
`timescale 1ns/1ps
module tpt_ahb_slave
    import tpt_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // register side
    tpt_reg_if.slave         rb
);
    tpt_bus_e    st_reg,  st_next;
    logic        wr_reg,  wr_next;
    logic [3:0]  idx_reg, idx_next;
    logic        rdy_reg, rdy_next;
    logic [31:0] rd_reg,  rd_next;
    logic        ok_reg,  ok_next;

    assign rb.idx     = idx_reg;
    assign rb.wdata   = hwdata;
    assign rb.wr_stb  = (st_reg == TPT_BUS_DATA) && wr_reg && ok_reg;
    assign hreadyout  = rdy_reg;
    assign hrdata     = rd_reg;
    assign hresp      = 1'b0;     // always okay

    // address phase latch, one wait state keeps hrdata registered
    always_comb begin
        st_next  = st_reg;
        wr_next  = wr_reg;
        idx_next = idx_reg;
        ok_next  = ok_reg;
        rdy_next = rdy_reg;
        rd_next  = rd_reg;
        case (st_reg)
            TPT_BUS_IDLE: begin
                rdy_next = 1'b1;
                if (hsel && hready && (htrans == TPT_HTRANS_NSEQ)) begin
                    st_next  = TPT_BUS_DATA;
                    wr_next  = hwrite;
                    idx_next = haddr[TPT_IDX_MSB:TPT_IDX_LSB];
                    ok_next  = (haddr[TPT_DEC_MSB:TPT_IDX_MSB+1] == '0) &&
                               (hsize == TPT_HSIZE_WORD);
                    rdy_next = 1'b0;
                end
            end
            TPT_BUS_DATA: begin
                st_next  = TPT_BUS_IDLE;
                rdy_next = 1'b1;
                rd_next  = (ok_reg && !wr_reg && rb.hit) ? rb.rdata : 32'h0000_0000;
            end
            default: st_next = TPT_BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg  <= TPT_BUS_IDLE;
            wr_reg  <= 1'b0;
            idx_reg <= 4'h0;
            ok_reg  <= 1'b0;
            rdy_reg <= 1'b1;
            rd_reg  <= 32'h0000_0000;
        end else begin
            st_reg  <= st_next;
            wr_reg  <= wr_next;
            idx_reg <= idx_next;
            ok_reg  <= ok_next;
            rdy_reg <= rdy_next;
            rd_reg  <= rd_next;
        end
    end
endmodule

// [rtl/tpt_timer.sv]
// tpt_timer: trigger-started pulse timer channel, retriggerable and one-shot modes
`timescale 1ns/1ps
module tpt_timer
    import tpt_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // external inputs
    input  wire logic        trigger_in,
    input  wire logic        event_in,
    // pulse outputs and match events
    output logic             pulse_output,
    output logic             aux_output,
    output logic             cycle_match_irq,
    output logic             width_match_irq
);
    // ************************************************************
    // bus slave and trigger edge
    // ************************************************************
    tpt_reg_if rbus ();
    logic      ext_trig;

    tpt_ahb_slave u_ahb (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rb        (rbus.slave)
    );

    // ************************************************************
    // software registers
    // ************************************************************
    logic        en_reg,    en_next;
    logic [2:0]  mode_reg,  mode_next;
    logic [7:0]  ioc2_reg,  ioc2_next;
    logic [7:0]  ioc1_reg,  ioc1_next;
    logic [7:0]  opt0_reg,  opt0_next;
    logic [15:0] ccr0_reg,  ccr0_next;
    logic [15:0] ccr1_reg,  ccr1_next;
    logic        swt_reg,   swt_next;
    logic        pend_reg,  pend_next;
    logic        load_sh;

    // trigger edge field of the edge select register
    function automatic logic [1:0] trig_edge_sel(input logic [7:0] r);
        trig_edge_sel = r[1:0];
    endfunction

    tpt_edge_det u_trig (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .pin_in     (trigger_in),
        .edge_sel   (trig_edge_sel(ioc2_reg)),
        .edge_pulse (ext_trig)
    );

    // write decode; event input is wired for the event-count modes left out here
    always_comb begin
        en_next   = en_reg;
        mode_next = mode_reg;
        ioc2_next = ioc2_reg;
        ioc1_next = ioc1_reg;
        opt0_next = opt0_reg;
        ccr0_next = ccr0_reg;
        ccr1_next = ccr1_reg;
        swt_next  = 1'b0;
        pend_next = load_sh ? 1'b0 : pend_reg;
        if (rbus.wr_stb) begin
            case (rbus.idx)
                TPT_IDX_CTL0: en_next = rbus.wdata[TPT_CE_BIT];
                TPT_IDX_CTL1: begin
                    mode_next = rbus.wdata[TPT_MODE_MSB:0];
                    swt_next  = rbus.wdata[TPT_EST_BIT];
                end
                TPT_IDX_IOC2: ioc2_next = rbus.wdata[7:0] & TPT_IOC2_MASK;
                TPT_IDX_IOC1: ioc1_next = rbus.wdata[7:0];
                TPT_IDX_OPT0: opt0_next = rbus.wdata[7:0];
                TPT_IDX_CCR0: ccr0_next = rbus.wdata[15:0];
                // width write arms copy, set beats the clear
                TPT_IDX_CCR1: begin
                    ccr1_next = rbus.wdata[15:0];
                    pend_next = 1'b1;
                end
                default: en_next = en_reg;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            en_reg   <= 1'b0;
            mode_reg <= 3'h0;
            ioc2_reg <= 8'h00;
            ioc1_reg <= 8'h00;
            opt0_reg <= 8'h00;
            ccr0_reg <= 16'h0000;
            ccr1_reg <= 16'h0000;
            swt_reg  <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            en_reg   <= en_next;
            mode_reg <= mode_next;
            ioc2_reg <= ioc2_next;
            ioc1_reg <= ioc1_next;
            opt0_reg <= opt0_next;
            ccr0_reg <= ccr0_next;
            ccr1_reg <= ccr1_next;
            swt_reg  <= swt_next;
            pend_reg <= pend_next;
        end
    end

    // ************************************************************
    // counter core
    // ************************************************************
    logic [15:0] cnt_reg,  cnt_next;
    logic        run_reg,  run_next;
    logic [15:0] csh_reg,  csh_next;
    logic [15:0] wsh_reg,  wsh_next;
    logic        pls_reg,  pls_next;
    logic        aux_reg,  aux_next;
    logic        sws_reg,  sws_next;
    logic        cirq_reg, cirq_next;
    logic        wirq_reg, wirq_next;
    logic        en_d_reg;
    logic        is_retrig, is_oneshot, trig, clr, start;
    logic [15:0] wuse, cuse;

    assign is_retrig  = (mode_reg == TPT_MODE_RETRIG);
    assign is_oneshot = (mode_reg == TPT_MODE_ONESHOT);
    assign trig       = en_reg && (ext_trig || swt_reg);
    assign start      = en_reg && !en_d_reg;
    assign load_sh    = start || (clr && pend_reg);
    // compare against the value that becomes the shadow at this edge
    assign wuse       = load_sh ? ccr1_reg : wsh_reg;
    assign cuse       = load_sh ? ccr0_reg : csh_reg;

    // next state of counter, run flag and outputs; capture/option not used by the core
    always_comb begin
        cnt_next  = cnt_reg;
        run_next  = run_reg;
        aux_next  = aux_reg;
        sws_next  = sws_reg;
        cirq_next = 1'b0;
        wirq_next = 1'b0;
        pls_next  = 1'b0;
        clr       = 1'b0;
        if (!en_reg || !(is_retrig || is_oneshot)) begin
            cnt_next = TPT_CNT_IDLE;
            run_next = 1'b0;
            aux_next = 1'b0;
            sws_next = 1'b0;
        end else if (is_retrig) begin
            if (trig) begin
                // restart from zero, either conflict side
                cnt_next = TPT_CNT_ZERO;
                run_next = 1'b1;
                clr      = 1'b1;
                sws_next = swt_reg;
                aux_next = swt_reg ? ~aux_reg : aux_reg;
            end else if (run_reg && cnt_reg == csh_reg) begin
                // cycle irq only without a trigger
                cnt_next  = TPT_CNT_ZERO;
                clr       = 1'b1;
                cirq_next = 1'b1;
                aux_next  = sws_reg ? ~aux_reg : aux_reg;
            end else if (run_reg) begin
                cnt_next = cnt_reg + TPT_CNT_ONE;
            end
            pls_next  = run_next && (cnt_next < wuse);
            // width irq at the match itself, not on trigger
            wirq_next = run_next && !trig && (cnt_next == wuse);
        end else begin
            if (!run_reg) begin
                if (trig) begin
                    cnt_next = TPT_CNT_ZERO;
                    run_next = 1'b1;
                    clr      = 1'b1;
                    sws_next = swt_reg;
                end
            end else if (cnt_reg == csh_reg) begin
                // end of pulse, park and wait
                cnt_next  = TPT_CNT_IDLE;
                run_next  = 1'b0;
                cirq_next = 1'b1;
            end else begin
                // triggers not looked at while running
                cnt_next = cnt_reg + TPT_CNT_ONE;
            end
            // delay of width, active to cycle value
            pls_next  = run_next && (cnt_next >= wuse) && (cnt_next <= cuse);
            // width irq on the match itself
            wirq_next = run_next && (cnt_next == wuse);
            // aux while counting on a soft start
            aux_next  = run_next && sws_next;
        end
    end

    // shadows take both compares on a counter clear after a width write
    always_comb begin
        csh_next = load_sh ? ccr0_reg : csh_reg;
        wsh_next = load_sh ? ccr1_reg : wsh_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg  <= TPT_CNT_IDLE;
            run_reg  <= 1'b0;
            csh_reg  <= 16'h0000;
            wsh_reg  <= 16'h0000;
            pls_reg  <= 1'b0;
            aux_reg  <= 1'b0;
            sws_reg  <= 1'b0;
            cirq_reg <= 1'b0;
            wirq_reg <= 1'b0;
            en_d_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            run_reg  <= run_next;
            csh_reg  <= csh_next;
            wsh_reg  <= wsh_next;
            pls_reg  <= pls_next;
            aux_reg  <= aux_next;
            sws_reg  <= sws_next;
            cirq_reg <= cirq_next;
            wirq_reg <= wirq_next;
            en_d_reg <= en_reg;
        end
    end

    assign pulse_output    = pls_reg;
    assign aux_output      = aux_reg;
    assign cycle_match_irq = cirq_reg;
    assign width_match_irq = wirq_reg;

    // ************************************************************
    // read mux
    // ************************************************************
    // counter read buffer is the live counter
    always_comb begin
        rbus.hit   = (rbus.idx <= TPT_IDX_LAST);
        rbus.rdata = 32'h0000_0000;
        case (rbus.idx)
            TPT_IDX_CTL0: rbus.rdata[TPT_CE_BIT] = en_reg;
            TPT_IDX_CTL1: rbus.rdata[TPT_MODE_MSB:0] = mode_reg;
            TPT_IDX_IOC2: rbus.rdata[7:0] = ioc2_reg;
            TPT_IDX_IOC1: rbus.rdata[7:0] = ioc1_reg;
            TPT_IDX_OPT0: rbus.rdata[7:0] = opt0_reg;
            TPT_IDX_CCR0: rbus.rdata[15:0] = ccr0_reg;
            TPT_IDX_CCR1: rbus.rdata[15:0] = ccr1_reg;
            TPT_IDX_CNT:  rbus.rdata[15:0] = cnt_reg;
            TPT_IDX_STAT: begin
                rbus.rdata[TPT_ST_RUN]  = run_reg;
                rbus.rdata[TPT_ST_PEND] = pend_reg;
            end
            default: rbus.rdata = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_rt_trig;
        en_reg && is_retrig && trig;
    endsequence

    property p_rt_restart;
        s_rt_trig |=> (cnt_reg == TPT_CNT_ZERO) && run_reg && !cirq_reg && !wirq_reg;
    endproperty
    a_rt_restart: assert property (p_rt_restart) else $error("retrigger did not restart");

    property p_soft_aux;
        en_reg && is_retrig && swt_reg |=> aux_reg != $past(aux_reg);
    endproperty
    a_soft_aux: assert property (p_soft_aux) else $error("soft trigger did not toggle aux");

    property p_pwm_level;
        is_retrig && $past(is_retrig) && $past(en_reg) && en_d_reg
            |-> pls_reg == (run_reg && cnt_reg < wsh_reg);
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

    property p_wirq_at_match;
        wirq_reg |-> cnt_reg == wsh_reg;
    endproperty
    a_wirq_at_match: assert property (p_wirq_at_match) else $error("width irq off match");

    property p_os_ignore;
        en_reg && is_oneshot && run_reg && trig && cnt_reg != csh_reg
            |=> cnt_reg == $past(cnt_reg) + TPT_CNT_ONE;
    endproperty
    a_os_ignore: assert property (p_os_ignore) else $error("one-shot took a trigger");

    sequence s_os_end;
        en_reg && is_oneshot && run_reg && cnt_reg == csh_reg;
    endsequence

    property p_os_stop;
        s_os_end |=> (cnt_reg == TPT_CNT_IDLE) && !run_reg && cirq_reg ##1 !cirq_reg;
    endproperty
    a_os_stop: assert property (p_os_stop) else $error("one-shot did not park");

    property p_os_aux;
        is_oneshot && aux_reg |-> run_reg;
    endproperty
    a_os_aux: assert property (p_os_aux) else $error("aux active while stopped");

    property p_disable;
        !en_reg |=> cnt_reg == TPT_CNT_IDLE && !pls_reg && !aux_reg && !run_reg;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not park");

    property p_reload;
        clr && pend_reg |=> wsh_reg == $past(ccr1_reg) && csh_reg == $past(ccr0_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("shadow copy missed");
endmodule

// [tb/tpt_load_model.sv]
// tpt_load_model: trigger source and pulse load for the timer bench
`timescale 1ns/1ps
module tpt_load_model (
    // clock
    input  wire logic ref_clk,
    // timer pins
    input  wire logic pulse_output,
    output logic      trigger_in
);
    initial trigger_in = 1'b0;
    // two rising edges, the second meant to land inside the pulse
    task automatic fire(input int gap);
        repeat (2) begin
            @(posedge ref_clk) trigger_in <= 1'b1;
            @(posedge ref_clk) trigger_in <= 1'b0;
            repeat (gap) @(posedge ref_clk);
        end
    endtask
    // sampled at falling edges, where the registered output has settled
    task automatic watch(input int n, output int hi, output int rises);
        logic last;
        hi = 0;
        rises = 0;
        last = pulse_output;
        repeat (n) begin
            @(negedge ref_clk);
            hi += int'(pulse_output === 1'b1);
            rises += int'(pulse_output === 1'b1 && last !== 1'b1);
            last = pulse_output;
        end
    endtask
endmodule

// [tb/test_triggered_pulse_timer.sv]
// test_triggered_pulse_timer: register-level tests of both trigger modes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_triggered_pulse_timer
    import tpt_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, pulse_output, aux_output, cycle_match_irq, width_match_irq;
    logic        trigger_in;
    int          n_errors = 0, num_checks = 0, n_cyc = 0, n_wid = 0;
    int          wtab[3] = '{2, 0, 4};
    int          htab[3] = '{20, 0, 40};
    int          itab[3] = '{10, 10, 0};

    always #5 ref_clk = ~ref_clk;
    // match pulses tallied at falling edges, where they have settled
    always @(negedge ref_clk) begin
        n_cyc += int'(cycle_match_irq === 1'b1);
        n_wid += int'(width_match_irq === 1'b1);
    end

    tpt_timer u_dut (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(TPT_HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .trigger_in, .event_in(1'b0), .pulse_output, .aux_output, .cycle_match_irq,
        .width_match_irq);
    tpt_load_model u_src (.ref_clk, .pulse_output, .trigger_in);

    // ************************************************************
    // bus tasks and verdict
    // ************************************************************
    // hready is read at the falling edge before the edge that samples it
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d,
                       output logic [31:0] r);
        logic ok;
        hsel <= 1'b1;
        haddr <= {26'h0, idx, 2'b00};
        htrans <= TPT_HTRANS_NSEQ;
        hwrite <= wr;
        do begin @(negedge ref_clk) ok = hreadyout; @(posedge ref_clk); end while (ok !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge ref_clk) ok = hreadyout;
            r = hrdata;
            @(posedge ref_clk);
        end while (ok !== 1'b1);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        int hi, ri, c0, w0;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        bus(1'b0, TPT_IDX_CNT, 32'h0, r); `CHK("idle count", 32'h0000FFFF, r)
        `CHK("okay resp", 1'b0, hresp)
        wr(TPT_IDX_IOC2, 32'hFF);
        bus(1'b0, TPT_IDX_IOC2, 32'h0, r); `CHK("edge sel", {24'h0, TPT_IOC2_MASK}, r)
        bus(1'b0, 4'hF, 32'h0, r); `CHK("unmapped", 32'h0, r)
        wr(TPT_IDX_CTL1, {29'h0, TPT_MODE_RETRIG});
        wr(TPT_IDX_CCR0, 32'h3);
        wr(TPT_IDX_CCR1, 32'h2);
        wr(TPT_IDX_CTL0, 32'h80);
        wr(TPT_IDX_CTL1, {25'h0, 1'b1, 3'h0, TPT_MODE_RETRIG});
        bus(1'b0, TPT_IDX_CNT, 32'h0, r); `CHK("run count", 1'b1, r <= 32'h3)
        // width-only changes: normal, zero and full duty
        for (int k = 0; k < 3; k++) begin
            wr(TPT_IDX_CCR1, wtab[k]);
            repeat (8) @(posedge ref_clk);
            c0 = n_cyc;
            w0 = n_wid;
            u_src.watch(40, hi, ri);
            // let the negedge tally finish its last sample before the counts are read
            @(posedge ref_clk);
            `CHK("high clocks", htab[k], hi)
            `CHK("cycle irqs", 10, n_cyc - c0)
            `CHK("width irqs", itab[k], n_wid - w0)
        end
        wr(TPT_IDX_CTL0, 32'h0);
        bus(1'b0, TPT_IDX_CNT, 32'h0, r); `CHK("stop count", 32'h0000FFFF, r)
        `CHK("pulse off", 1'b0, pulse_output)
        wr(TPT_IDX_CTL1, {29'h0, TPT_MODE_ONESHOT});
        wr(TPT_IDX_IOC2, {30'h0, TPT_EDGE_RISE});
        wr(TPT_IDX_CCR0, 32'h5);
        wr(TPT_IDX_CCR1, 32'h2);
        wr(TPT_IDX_CTL0, 32'h80);
        c0 = n_cyc;
        w0 = n_wid;
        fork
            u_src.fire(3);
            u_src.watch(30, hi, ri);
        join
        `CHK("shot width", 4, hi)
        `CHK("shot count", 1, ri)
        `CHK("shot irqs", 2, (n_cyc - c0) + (n_wid - w0))
        // soft-started shot: aux is up while counting and down once parked
        wr(TPT_IDX_CTL1, {25'h0, 1'b1, 3'h0, TPT_MODE_ONESHOT});
        @(negedge ref_clk);
        `CHK("aux counting", 1'b1, aux_output)
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("aux parked", 1'b0, aux_output)
        @(posedge ref_clk);
        bus(1'b0, TPT_IDX_CNT, 32'h0, r); `CHK("parked", 32'h0000FFFF, r)
        give_verdict();
    end
endmodule
